// ### rtl/zq_sched.v
`timescale 1ns/100ps
`default_nettype none
`include "reorder_zq_defs.vh"
// Serialized ZQ calibration toward two ranks sharing one resistor
module zq_sched #(
	parameter [15:0] ZQCL_PERIOD = `ZQCL_PERIOD,
	parameter [15:0] ZQCS_PERIOD = `ZQCS_PERIOD
) (
	input wire clk,
	input wire rst,
	input wire auto_zqcl_en,
	input wire auto_zqcs_en,
	input wire sw_zq_req,
	input wire sw_zq_long,
	input wire sw_zq_cs,
	output reg zq_cmd,
	output reg zq_long,
	output reg zq_cs,
	output wire zq_busy,
	output wire sw_zq_ack
);
	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_CS0 = 4'h2;
	localparam [3:0] S_CS1 = 4'h4;
	localparam [3:0] S_SW = 4'h8;
	localparam integer ZQCL_INT = `ZQCL_CYCLES;
	localparam integer ZQCS_INT = `ZQCS_CYCLES;
	localparam [15:0] ZQCL_CYC = ZQCL_INT[15:0];
	localparam [15:0] ZQCS_CYC = ZQCS_INT[15:0];
	reg [3:0] state_q;
	reg [15:0] wait_q;
	reg [15:0] lper_q;
	reg [15:0] sper_q;
	reg long_pend_q;
	reg short_pend_q;
	wire [15:0] intv = zq_long ? ZQCL_CYC : ZQCS_CYC;
	// A period that expires while its pair finishes must stay pending
	wire lfire = auto_zqcl_en && (lper_q == ZQCL_PERIOD - 16'h0001);
	wire sfire = auto_zqcs_en && (sper_q == ZQCS_PERIOD - 16'h0001);
	assign zq_busy = (state_q != S_IDLE);
	assign sw_zq_ack = (state_q == S_IDLE) && sw_zq_req && !long_pend_q && !short_pend_q;
	always @(posedge clk) begin
		if (rst) begin
			state_q <= S_IDLE;
			wait_q <= 16'h0000;
			lper_q <= 16'h0000;
			sper_q <= 16'h0000;
			long_pend_q <= 1'b0;
			short_pend_q <= 1'b0;
			zq_cmd <= 1'b0;
			zq_long <= 1'b0;
			zq_cs <= 1'b0;
		end else begin
			zq_cmd <= 1'b0;
			// Periodic timers run only while their automatic mode is enabled
			if (!auto_zqcl_en) begin
				lper_q <= 16'h0000;
			end else if (lper_q == ZQCL_PERIOD - 16'h0001) begin
				lper_q <= 16'h0000;
				long_pend_q <= 1'b1;
			end else begin
				lper_q <= lper_q + 16'h0001;
			end
			if (!auto_zqcs_en) begin
				sper_q <= 16'h0000;
			end else if (sper_q == ZQCS_PERIOD - 16'h0001) begin
				sper_q <= 16'h0000;
				short_pend_q <= 1'b1;
			end else begin
				sper_q <= sper_q + 16'h0001;
			end
			if (wait_q != 16'h0000) begin
				wait_q <= wait_q - 16'h0001;
			end
			case (state_q)
			S_IDLE: begin
				if (long_pend_q || short_pend_q) begin
					zq_cmd <= 1'b1;
					zq_long <= long_pend_q;
					zq_cs <= 1'b0;
					wait_q <= long_pend_q ? ZQCL_CYC : ZQCS_CYC;
					state_q <= S_CS0;
				end else if (sw_zq_req) begin
					zq_cmd <= 1'b1;
					zq_long <= sw_zq_long;
					zq_cs <= sw_zq_cs;
					wait_q <= sw_zq_long ? ZQCL_CYC : ZQCS_CYC;
					state_q <= S_SW;
				end
			end
			S_CS0: begin
				// Second rank only after the first interval has fully run out
				if (wait_q == 16'h0000) begin
					zq_cmd <= 1'b1;
					zq_cs <= 1'b1;
					wait_q <= intv;
					state_q <= S_CS1;
				end
			end
			S_CS1: begin
				if (wait_q == 16'h0000) begin
					if (zq_long) begin
						long_pend_q <= lfire;
					end else begin
						short_pend_q <= sfire;
					end
					state_q <= S_IDLE;
				end
			end
			S_SW: begin
				if (wait_q == 16'h0000) begin
					state_q <= S_IDLE;
				end
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ### rtl/reorder_zq_defs.vh
`ifndef REORDER_ZQ_DEFS_VH
`define REORDER_ZQ_DEFS_VH
// Aging and guard
`define AGE_W 4
`define AGE_LEVEL_DEFAULT 4'hf
`define GUARD_W 4
`define GUARD_RESET 4'h0
// Request slots
`define SLOTS 4
`define SCORE_W 4
`define SCORE_MAX 4'hf
// Calibration intervals in ns and cycles at 50 ns per clock
`define CLK_PERIOD_NS 50
`define ZQCL_TIME_NS 360
`define ZQCS_TIME_NS 90
`define ZQCL_CYCLES ((`ZQCL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ZQCS_CYCLES ((`ZQCS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Automatic calibration periods in cycles
`define ZQCL_PERIOD 16'h0fa0
`define ZQCS_PERIOD 16'h07d0
`define CNT_W 16
`endif

// ### rtl/reorder_aging_zq.v
// Operation
// - After reordering a request at maximum dynamic score waits a further guard count before top priority.
// - Waiting requests age so low-priority traffic is never starved.
// - A request whose aging counter reaches 15 receives the highest-priority tag.
// - ZQ commands never go to both chip selects at once; they are serialized.
// - Automatic long and short calibrations can each be disabled on their own.
// - After any ZQ command all data transfers are held off until its interval elapses.
`timescale 1ns/100ps
`default_nettype none
`include "reorder_zq_defs.vh"
module reorder_aging_zq #(
	parameter N = `SLOTS,
	parameter [15:0] ZQCL_PERIOD = `ZQCL_PERIOD,
	parameter [15:0] ZQCS_PERIOD = `ZQCS_PERIOD
) (
	// Clock and reset
	input wire CLK,
	input wire RST,
	// Reorder control
	input wire REORDER_EN,
	input wire [3:0] REORDER_AGING_GUARD,
	// Request slots, one bit or field per slot
	input wire [N-1:0] REQ_VALID,
	input wire [N*4-1:0] REQ_SCORE,
	// Memory side grant
	input wire MEM_READY,
	output wire [N-1:0] GRANT,
	output wire [N-1:0] TOP_PRIO,
	// ZQ control
	input wire AUTO_ZQCL_EN,
	input wire AUTO_ZQCS_EN,
	input wire SW_ZQ_REQ,
	input wire SW_ZQ_LONG,
	input wire SW_ZQ_CS,
	output wire SW_ZQ_ACK,
	output wire ZQ_CMD,
	output wire ZQ_LONG,
	output wire ZQ_CS,
	output wire XFER_HOLD
);
	wire zq_busy;
	wire issue_ok = MEM_READY && !zq_busy;
	reg [N-1:0] gnt;
	reg [3:0] best_score;
	reg found_top;
	integer i;
	assign XFER_HOLD = zq_busy;
	assign GRANT = gnt;
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : slot
			reg [3:0] age_q;
			reg [3:0] guard_q;
			reg top_q;
			wire [3:0] score = REQ_SCORE[g*4 +: 4];
			wire at_max = REORDER_EN && (score == `SCORE_MAX);
			assign TOP_PRIO[g] = top_q;
			always @(posedge CLK) begin
				if (RST || !REQ_VALID[g] || gnt[g]) begin
					age_q <= 4'h0;
					guard_q <= 4'h0;
					top_q <= 1'b0;
				end else begin
					// Age every waiting request so none starves
					if (age_q != `AGE_LEVEL_DEFAULT) begin
						age_q <= age_q + 4'h1;
					end
					// Guard counts only once the top aging level and max score are reached
					if (at_max && age_q == `AGE_LEVEL_DEFAULT &&
							guard_q != REORDER_AGING_GUARD) begin
						guard_q <= guard_q + 4'h1;
					end
					if (age_q == `AGE_LEVEL_DEFAULT &&
							(!at_max || guard_q == REORDER_AGING_GUARD)) begin
						top_q <= 1'b1;
					end
				end
			end
		end
	endgenerate
	// Top priority tag beats score; lowest slot wins ties
	always @* begin
		gnt = {N{1'b0}};
		best_score = 4'h0;
		found_top = 1'b0;
		if (issue_ok) begin
			for (i = 0; i < N; i = i + 1) begin
				if (REQ_VALID[i] && TOP_PRIO[i] && !found_top) begin
					found_top = 1'b1;
					gnt = {N{1'b0}};
					gnt[i] = 1'b1;
				end
			end
			if (!found_top) begin
				for (i = 0; i < N; i = i + 1) begin
					if (REQ_VALID[i] && (gnt == {N{1'b0}} ||
							(REORDER_EN && REQ_SCORE[i*4 +: 4] > best_score))) begin
						gnt = {N{1'b0}};
						gnt[i] = 1'b1;
						best_score = REQ_SCORE[i*4 +: 4];
					end
				end
			end
		end
	end
	zq_sched #(
		.ZQCL_PERIOD(ZQCL_PERIOD),
		.ZQCS_PERIOD(ZQCS_PERIOD)
	) u_zq (
		.clk(CLK),
		.rst(RST),
		.auto_zqcl_en(AUTO_ZQCL_EN),
		.auto_zqcs_en(AUTO_ZQCS_EN),
		.sw_zq_req(SW_ZQ_REQ),
		.sw_zq_long(SW_ZQ_LONG),
		.sw_zq_cs(SW_ZQ_CS),
		.zq_cmd(ZQ_CMD),
		.zq_long(ZQ_LONG),
		.zq_cs(ZQ_CS),
		.zq_busy(zq_busy),
		.sw_zq_ack(SW_ZQ_ACK)
	);
endmodule
`default_nettype wire

// ### verification/reorder_zq_properties.sv
`timescale 1ns/100ps
`default_nettype none
module reorder_zq_properties #(parameter N = 4) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Reordering
	input wire logic REORDER_EN,
	input wire logic [3:0] REORDER_AGING_GUARD,
	input wire logic [N-1:0] REQ_VALID,
	input wire logic [N-1:0] GRANT,
	input wire logic [N-1:0] TOP_PRIO,
	// Calibration
	input wire logic SW_ZQ_ACK,
	input wire logic ZQ_CMD,
	input wire logic ZQ_LONG,
	input wire logic XFER_HOLD
);
	logic [5:0] wait_q;
	logic [5:0] lim;
	localparam int ZQCL_CYC = 8;
	localparam int ZQCS_CYC = 2;
	logic [5:0] since_q;
	logic last_long_q;
	assign lim = {2'h0, REORDER_AGING_GUARD};
	// Cycles since the last command, to check the spacing between ranks
	always @(posedge CLK) begin
		if (RST) begin
			since_q <= 6'h3f;
			last_long_q <= 1'b0;
		end else if (ZQ_CMD) begin
			since_q <= 6'h1;
			last_long_q <= ZQ_LONG;
		end else if (since_q != 6'h3f) begin
			since_q <= since_q + 6'h1;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// Saturates so a starved slot never wraps back under the bounds
	always @(posedge CLK) begin
		if (RST || !REORDER_EN || !REQ_VALID[0] || GRANT[0])
			wait_q <= 6'h0;
		else if (wait_q != 6'h3f)
			wait_q <= wait_q + 6'h1;
	end
	sequence long_hold;
		XFER_HOLD [*7];
	endsequence
	chk_hold_no_grant: assert property (XFER_HOLD |-> GRANT == '0)
		else $error("grant in hold");
	chk_grant_valid: assert property ((GRANT & ~REQ_VALID) == '0 && $onehot0(GRANT))
		else $error("bad grant");
	chk_top_wins: assert property (|(TOP_PRIO & REQ_VALID) && |GRANT |-> |(GRANT & TOP_PRIO))
		else $error("top lost");
	chk_guard_early: assert property (wait_q != 0 && wait_q < lim + 6'he |-> !TOP_PRIO[0])
		else $error("early top");
	chk_age_top: assert property (wait_q >= lim + 6'h14 |-> TOP_PRIO[0])
		else $error("no top");
	chk_sw_issue: assert property (SW_ZQ_ACK |=> ZQ_CMD)
		else $error("no command");
	chk_zq_serial: assert property (ZQ_CMD |-> since_q > (last_long_q ? ZQCL_CYC : ZQCS_CYC))
		else $error("overlap");
	chk_long_hold: assert property (ZQ_CMD && ZQ_LONG |=> long_hold)
		else $error("short hold");
	chk_hold_ends: assert property ($rose(XFER_HOLD) |-> ##[2:20] !XFER_HOLD)
		else $error("hold stuck");
endmodule
bind reorder_aging_zq reorder_zq_properties #(.N(N)) props (
	.CLK(CLK),
	.RST(RST),
	.REORDER_EN(REORDER_EN),
	.REORDER_AGING_GUARD(REORDER_AGING_GUARD),
	.REQ_VALID(REQ_VALID),
	.GRANT(GRANT),
	.TOP_PRIO(TOP_PRIO),
	.SW_ZQ_ACK(SW_ZQ_ACK),
	.ZQ_CMD(ZQ_CMD),
	.ZQ_LONG(ZQ_LONG),
	.XFER_HOLD(XFER_HOLD)
);
`default_nettype wire

// ### verification/mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// A slow part accepts one cycle in three
// Calibration pin taken as tied to supply, so the part runs at full drive
module mem_model (
	input wire logic CLK,
	input wire logic slow,
	output logic MEM_READY
);
	logic [2:0] ph_q = 3'h1;
	always @(posedge CLK) ph_q <= {ph_q[1:0], ph_q[2]};
	assign MEM_READY = !slow || ph_q[0];
endmodule
`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk = 0, rst = 1, rdy = 1, slow = 0, zl = 0, zs = 0, sreq = 0, slong = 0, scs = 0, ren = 1;
	logic [3:0] guard = 4'h0, valid = 4'h0, grant, top;
	logic [15:0] score = 16'h000f, lf = 16'd14046;
	logic mrdy, ack, cmd, zlong, zcs, hold;
	int errors = 0, num_checks = 0, cyc = 0, n = 0, nl = 0, nc = 0, k, a, b, c;
	always #25 clk = ~clk;
	mem_model mem (.CLK(clk), .slow(slow), .MEM_READY(mrdy));
	reorder_aging_zq #(.ZQCL_PERIOD(16'd40), .ZQCS_PERIOD(16'd20)) dut (.CLK(clk), .RST(rst),
		.REORDER_EN(ren), .REORDER_AGING_GUARD(guard), .REQ_VALID(valid), .REQ_SCORE(score),
		.MEM_READY(mrdy & rdy), .GRANT(grant), .TOP_PRIO(top), .AUTO_ZQCL_EN(zl),
		.AUTO_ZQCS_EN(zs), .SW_ZQ_REQ(sreq), .SW_ZQ_LONG(slong), .SW_ZQ_CS(scs),
		.SW_ZQ_ACK(ack), .ZQ_CMD(cmd), .ZQ_LONG(zlong), .ZQ_CS(zcs), .XFER_HOLD(hold));
	function automatic logic [15:0] nx(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	// Shortest wait behind the previous command's interval
	function automatic int gap(input int i);
		return i == 0 ? 0 : (i % 2 ? 2 : 8);
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic tk(input int m);
		repeat (m) @(negedge clk);
	endtask
	task automatic rnd(input int m);
		repeat (m) begin
			@(negedge clk);
			lf = nx(lf);
			valid = valid | lf[3:0];
			score = {lf[7:0], lf[15:8]};
		end
	endtask
	// A granted request is consumed at the edge
	always @(posedge clk) begin
		valid <= valid & ~grant;
		cyc <= cyc + 1;
		n <= n + (cmd === 1'b1);
		nl <= nl + ((cmd & zlong) === 1'b1);
		nc <= nc + ((cmd & zcs) === 1'b1);
		if (cyc == 5000) begin
			errors++;
			end_sim;
		end
	end
	initial begin
		tk(6);
		rst = 0;
		for (int g = 0; g < 16; g += 5) begin
			guard = g[3:0];
			rdy = 0;
			valid = 4'h1;
			k = 0;
			while (top[0] !== 1'b1 && k < 60) begin
				tk(1);
				k++;
			end
			check(k >= g + 14 && k <= g + 20, 1);
			valid = 4'hf;
			rdy = 1;
			#1 check(grant, 4'h1);
			tk(9);
		end
		// Reordering off: lowest slot wins; on: the higher score wins
		ren = 0;
		valid = 4'h6;
		score = 16'h0f10;
		#1 check(grant, 4'h2);
		ren = 1;
		#1 check(grant, 4'h4);
		tk(3);
		guard = 0;
		slow = 1;
		rnd(300);
		slow = 0;
		tk(20);
		for (int i = 0; i < 4; i++) begin
			slong = i[0];
			scs = i[1];
			sreq = 1;
			k = 0;
			while (ack !== 1'b1 && k < 40) begin
				tk(1);
				k++;
			end
			check(k >= gap(i), 1);
			tk(1);
			check({cmd, zlong, zcs}, {1'b1, i[0], i[1]});
			sreq = 0;
			tk(1);
		end
		for (int m = 1; m < 3; m++) begin
			zl = m[0];
			zs = m[1];
			a = n;
			b = nl;
			c = nc;
			rnd(200);
			check(n > a && nc > c, 1);
			check(nl - b == (m == 1 ? n - a : 0), 1);
			zl = 0;
			zs = 0;
			tk(40);
		end
		a = n;
		rnd(150);
		check(n == a, 1);
		end_sim;
	end
endmodule
`default_nettype wire
